// ==== design/cmd_perf_regs.sv ====
// Behaviour
// - pci reset rise clears power state
// - sticky wake holds until status cleared
// - non-sticky wake drops on power up
// - led select: three or four leds
// - fifo size code 11=1K, 10=2K
// - clock-run off disables clkrun pin
// - pm disabled gives zero cap pointer
// - pm enable mirrored to config bit
// - gated wake events in pm mode
// - special frame detect default from bit
// - forced wake bit drives wake signal
// - pointer reset bit resets pattern pointer
// - pause from negotiation, driver may override
// - threshold disabled means fixed 64 bytes
// - drain code 00=32,01=64,10=store-forward
// - underrun auto recovery enable, reset zero
// - accumulate read latency clocks
// - accumulate bus master dwords
// - counter read-only, cleared by read
// - eeprom loads command defaults
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cmd_perf_regs
   import cmd_perf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // eeprom recall
   input wire logic ee_load,
   input wire logic [EE_WIDTH-1:0] ee_data,
   // pins from outside
   input wire logic pci_reset_pin,
   input wire logic power_up,
   input wire logic link_change,
   input wire logic wake_frame_seen,
   input wire logic special_frame_seen,
   // same-clock inputs from the mac
   input wire logic an_done,
   input wire logic an_pause,
   input wire logic read_pending,
   input wire logic dword_moved,
   // wake and clock-run
   output logic wake_out,
   output logic clkrun_enable,
   // leds
   output logic led_speed,
   output logic led_fast_link,
   output logic led_slow_link,
   output logic led_activity,
   output logic led_link_act,
   output logic led_duplex_col,
   input wire logic link_up,
   input wire logic speed_fast,
   input wire logic activity,
   input wire logic duplex_col,
   // datapath controls
   output logic [11:0] rx_fifo_bytes,
   output logic [6:0] rx_threshold_bytes,
   output logic rx_store_forward,
   output logic pause_enable,
   output logic underrun_auto_recover,
   output logic pattern_pointer_reset,
   output logic soft_int_status,
   output logic [7:0] cap_pointer,
   output logic config_status_bit20
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic power_state_auto_clear;
   logic wake_sticky;
   logic led_count_select;
   logic [1:0] rx_fifo_size;
   logic clock_run_off;
   logic power_mgmt_enable;
   logic wake_frame_default_on;
   logic link_wake_select;
   logic forced_wake_assert;
   logic pause_forced;
   logic rx_threshold_enable;
   logic [1:0] rx_drain_threshold;
   logic [1:0] power_state_field;
   logic pme_status;
   logic pme_enable;
   logic special_frame_enable;
   logic pause_override;
   logic [15:0] latency_clocks;
   logic [7:0] dword_count;
   logic [6:0] sync_q;
   logic pci_reset_q, power_up_q, link_q, wframe_q, sframe_q;
   logic pci_reset_d;
   logic power_up_d;
   logic req;
   logic wr;
   logic rd_perf;
   logic wake_event;
   logic [31:0] command_view;
   logic [31:0] pm_view;
   logic [31:0] next_dat;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   bit_sync #(.WIDTH(5)) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({pci_reset_pin, power_up, link_change, wake_frame_seen, special_frame_seen}),
      .sync_out({pci_reset_q, power_up_q, link_q, wframe_q, sframe_q})
   );
   assign sync_q = {2'b00, pci_reset_q, power_up_q, link_q, wframe_q, sframe_q};

   // delayed copies for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         pci_reset_d <= 1'b0;
         power_up_d <= 1'b0;
      end else begin
         pci_reset_d <= pci_reset_q;
         power_up_d <= power_up_q;
      end
   end

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // one-wait answer: ack in the cycle after the request is seen
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   assign rd_perf = req && !wb_we_i && wb_adr_i == OFF_PERF;

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // ------------------------------------------------------------
   // command register, high half (eeprom recalled)
   // ------------------------------------------------------------
   // eeprom recall sets defaults
   always_ff @(posedge clk) begin
      if (rst) begin
         power_state_auto_clear <= 1'b0;
         wake_sticky <= 1'b0;
         led_count_select <= 1'b0;
         rx_fifo_size <= FIFO_2K;
         clock_run_off <= 1'b0;
         wake_frame_default_on <= 1'b1;
         link_wake_select <= 1'b0;
      end else if (ee_load) begin
         {power_state_auto_clear, wake_sticky, led_count_select, rx_fifo_size,
          clock_run_off, wake_frame_default_on, link_wake_select} <= ee_data[7:0];
      end else if (wr && wb_adr_i == OFF_COMMAND) begin
         if (wb_sel_i[3]) begin
            power_state_auto_clear <= wb_dat_i[BIT_PWR_CLR];
            wake_sticky <= wb_dat_i[BIT_WAKE_STICKY];
         end
         if (wb_sel_i[2]) begin
            led_count_select <= wb_dat_i[BIT_LED_SEL];
            rx_fifo_size <= wb_dat_i[POS_FIFO_SIZE +: 2];
            clock_run_off <= wb_dat_i[BIT_CLKRUN_OFF];
            wake_frame_default_on <= wb_dat_i[BIT_WAKE_DEF];
            link_wake_select <= wb_dat_i[BIT_LINK_WAKE_SEL];
         end
      end
   end

   // power management enable is read-only, taken from eeprom bit 8 at recall
   always_ff @(posedge clk) begin
      if (rst) begin
         power_mgmt_enable <= 1'b1;
      end else if (ee_load) begin
         power_mgmt_enable <= ee_data[8];
      end
   end

   // ------------------------------------------------------------
   // command register, low half
   // ------------------------------------------------------------
   // underrun recovery resets zero
   always_ff @(posedge clk) begin
      if (rst) begin
         forced_wake_assert <= 1'b0;
         pattern_pointer_reset <= 1'b0;
         pause_forced <= 1'b0;
         pause_override <= 1'b0;
         rx_threshold_enable <= 1'b0;
         rx_drain_threshold <= DRAIN_64;
         underrun_auto_recover <= 1'b0;
      end else if (wr && wb_adr_i == OFF_COMMAND && wb_sel_i[0]) begin
         forced_wake_assert <= wb_dat_i[BIT_FORCED_WAKE];
         pattern_pointer_reset <= wb_dat_i[BIT_PTR_RESET];
         pause_forced <= wb_dat_i[BIT_PAUSE];
         // override only honoured once negotiation is over
         pause_override <= an_done;
         rx_threshold_enable <= wb_dat_i[BIT_RX_THR_EN];
         rx_drain_threshold <= wb_dat_i[POS_DRAIN +: 2];
         underrun_auto_recover <= wb_dat_i[BIT_UNDERRUN];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pause_enable <= 1'b0;
      end else begin
         pause_enable <= pause_override ? pause_forced : an_pause;
      end
   end

   // soft interrupt raise
   // a write sets or clears it
   always_ff @(posedge clk) begin
      if (rst) begin
         soft_int_status <= 1'b0;
      end else if (wr && wb_adr_i == OFF_COMMAND && wb_sel_i[0]) begin
         soft_int_status <= wb_dat_i[BIT_SOFT_INT];
      end
   end

   // ------------------------------------------------------------
   // power management state
   // ------------------------------------------------------------
   // clear on pci reset rise
   always_ff @(posedge clk) begin
      if (rst) begin
         power_state_field <= PWR_D0;
         pme_enable <= 1'b0;
      end else if (power_state_auto_clear && pci_reset_q && !pci_reset_d) begin
         power_state_field <= PWR_D0;
      end else if (wr && wb_adr_i == OFF_PM_STATUS && wb_sel_i[0]) begin
         power_state_field <= wb_dat_i[1:0];
         pme_enable <= wb_dat_i[BIT_PME_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         special_frame_enable <= 1'b0;
      end else begin
         special_frame_enable <= power_mgmt_enable && wake_frame_default_on;
      end
   end

   assign wake_event = power_mgmt_enable && pme_enable &&
      ((wframe_q) || (sframe_q && special_frame_enable) ||
       (link_q && !link_wake_select));

   // power up drops it when wake is not sticky
   // set wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pme_status <= 1'b0;
      end else if (wake_event) begin
         pme_status <= 1'b1;
      end else if (wr && wb_adr_i == OFF_PM_STATUS && wb_sel_i[1] &&
                   wb_dat_i[BIT_PME_STATUS]) begin
         pme_status <= 1'b0;
      end else if (!wake_sticky && power_up_q && !power_up_d) begin
         pme_status <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wake_out <= 1'b0;
      end else begin
         wake_out <= forced_wake_assert || pme_status;
      end
   end

   // ------------------------------------------------------------
   // derived controls
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         clkrun_enable <= 1'b1;
         rx_fifo_bytes <= 12'h800;
         rx_threshold_bytes <= 7'h40;
         rx_store_forward <= 1'b0;
         cap_pointer <= CAP_PTR_PM;
         config_status_bit20 <= 1'b1;
      end else begin
         clkrun_enable <= !clock_run_off;
         rx_fifo_bytes <= (rx_fifo_size == FIFO_1K) ? 12'h400 : 12'h800;
         rx_threshold_bytes <= (!rx_threshold_enable || rx_drain_threshold == DRAIN_64) ?
            7'h40 : 7'h20;
         rx_store_forward <= rx_threshold_enable && rx_drain_threshold == DRAIN_SAF;
         cap_pointer <= power_mgmt_enable ? CAP_PTR_PM : 8'h00;
         config_status_bit20 <= power_mgmt_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         led_speed <= 1'b0;
         led_fast_link <= 1'b0;
         led_slow_link <= 1'b0;
         led_activity <= 1'b0;
         led_link_act <= 1'b0;
         led_duplex_col <= 1'b0;
      end else begin
         led_speed <= !led_count_select && speed_fast;
         led_link_act <= !led_count_select && (link_up || activity);
         led_fast_link <= led_count_select && link_up && speed_fast;
         led_slow_link <= led_count_select && link_up && !speed_fast;
         led_activity <= led_count_select && activity;
         led_duplex_col <= duplex_col;
      end
   end

   // ------------------------------------------------------------
   // performance counter
   // ------------------------------------------------------------
   perf_counter u_perf (
      .clk(clk),
      .rst(rst),
      .read_pending(read_pending),
      .dword_moved(dword_moved),
      .read_clear(rd_perf),
      .latency_clocks(latency_clocks),
      .dword_count(dword_count)
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   assign command_view = {6'h00, power_state_auto_clear, wake_sticky, led_count_select,
      rx_fifo_size, clock_run_off, power_mgmt_enable, wake_frame_default_on,
      link_wake_select, 9'h000, forced_wake_assert, pattern_pointer_reset, pause_enable,
      rx_threshold_enable, rx_drain_threshold, soft_int_status, underrun_auto_recover};
   assign pm_view = {16'h0000, pme_status, 6'h00, pme_enable, 6'h00, power_state_field};

   always_comb begin
      case (wb_adr_i)
         OFF_COMMAND: next_dat = command_view;
         OFF_PERF: next_dat = {latency_clocks, 8'h00, dword_count};
         OFF_PM_STATUS: next_dat = pm_view;
         OFF_STRAP: next_dat = {25'h0000000, sync_q};
         default: next_dat = 32'h0000_0000;
      endcase
   end

   // read data registered with the ack
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= next_dat;
      end
   end
endmodule : cmd_perf_regs
`default_nettype wire

// ==== design/cmd_perf_pkg.sv ====
package cmd_perf_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_COMMAND = 8'h88;
   localparam logic [7:0] OFF_PERF = 8'h8C;
   localparam logic [7:0] OFF_PM_STATUS = 8'h90;
   localparam logic [7:0] OFF_STRAP = 8'hA8;

   // ------------------------------------------------------------
   // command register field positions
   // ------------------------------------------------------------
   localparam int BIT_PWR_CLR = 25;
   localparam int BIT_WAKE_STICKY = 24;
   localparam int BIT_LED_SEL = 23;
   localparam int POS_FIFO_SIZE = 21;
   localparam int BIT_CLKRUN_OFF = 20;
   localparam int BIT_PM_EN = 19;
   localparam int BIT_WAKE_DEF = 18;
   localparam int BIT_LINK_WAKE_SEL = 17;
   localparam int BIT_FORCED_WAKE = 7;
   localparam int BIT_PTR_RESET = 6;
   localparam int BIT_PAUSE = 5;
   localparam int BIT_RX_THR_EN = 4;
   localparam int POS_DRAIN = 2;
   localparam int BIT_SOFT_INT = 1;
   localparam int BIT_UNDERRUN = 0;

   // power status register field positions
   localparam int BIT_PME_STATUS = 15;
   localparam int BIT_PME_EN = 8;

   // ------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------
   localparam logic [1:0] FIFO_1K = 2'h3;
   localparam logic [1:0] FIFO_2K = 2'h2;
   localparam logic [1:0] DRAIN_32 = 2'h0;
   localparam logic [1:0] DRAIN_64 = 2'h1;
   localparam logic [1:0] DRAIN_SAF = 2'h2;
   localparam logic [1:0] PWR_D0 = 2'h0;
   localparam logic [7:0] CAP_PTR_PM = 8'h40;
   localparam logic [31:0] PERF_RESET = 32'h0000_0000;
   // eeprom image width: 8 command bits plus the pm enable bit
   localparam int EE_WIDTH = 9;

   // ------------------------------------------------------------
   // shared helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] sat_add16(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add16 = s[16] ? 16'hFFFF : s[15:0];
   endfunction : sat_add16

endpackage : cmd_perf_pkg

// ==== design/bit_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module bit_sync
   import cmd_perf_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   if (WIDTH < 1) begin : g_width_check
      $error("bit_sync width must be positive");
   end

   // two stages; only the second stage reads meta
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : bit_sync
`default_nettype wire

// ==== design/perf_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module perf_counter
   import cmd_perf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // events from the bus master engine
   input wire logic read_pending,
   input wire logic dword_moved,
   // clear on read
   input wire logic read_clear,
   // value
   output logic [15:0] latency_clocks,
   output logic [7:0] dword_count
);
   // ------------------------------------------------------------
   // accumulators
   // ------------------------------------------------------------
   // count waiting clocks
   // saturate rather than wrap so a slow read never looks fast
   always_ff @(posedge clk) begin
      if (rst) begin
         latency_clocks <= PERF_RESET[31:16];
      end else if (read_clear) begin
         latency_clocks <= {15'h0000, read_pending};
      end else if (read_pending) begin
         latency_clocks <= sat_add16(latency_clocks, 16'h0001);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dword_count <= PERF_RESET[7:0];
      end else if (read_clear) begin
         dword_count <= {7'h00, dword_moved};
      end else if (dword_moved && dword_count != 8'hFF) begin
         dword_count <= dword_count + 8'h01;
      end
   end
endmodule : perf_counter
`default_nettype wire

// ==== tb/cmd_perf_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmd_perf_props
   import cmd_perf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // eeprom and controls
   input wire logic ee_load,
   input wire logic [EE_WIDTH-1:0] ee_data,
   input wire logic wake_out,
   input wire logic clkrun_enable,
   input wire logic [11:0] rx_fifo_bytes,
   input wire logic [6:0] rx_threshold_bytes,
   input wire logic rx_store_forward,
   input wire logic underrun_auto_recover,
   input wire logic soft_int_status,
   input wire logic [7:0] cap_pointer,
   input wire logic config_status_bit20
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // command write seen at its acknowledging edge
   // ------------------------------------------------------------
   sequence cmd_wr(b, v);
      wb_ack_o && wb_we_i && wb_adr_i == OFF_COMMAND && wb_sel_i[b / 8] && wb_dat_i[b] == v;
   endsequence
   // one wait state, then a single pulse
   AST_TAKE_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_RESET_VALUES: assert property ($fell(rst) |-> clkrun_enable && rx_fifo_bytes == 12'h800 && rx_threshold_bytes == 7'h40)
      else $error("wrong values after reset");
   AST_FORCED_WAKE: assert property (cmd_wr(BIT_FORCED_WAKE, 1'b1) |-> ##[0:3] wake_out)
      else $error("forced wake not driven");
   AST_CLKRUN_OFF: assert property (cmd_wr(BIT_CLKRUN_OFF, 1'b1) |-> ##[0:3] !clkrun_enable)
      else $error("clock run still enabled");
   AST_SOFT_INT: assert property (cmd_wr(BIT_SOFT_INT, 1'b1) |-> ##[0:3] soft_int_status)
      else $error("soft interrupt not raised");
   AST_UNDERRUN: assert property (cmd_wr(BIT_UNDERRUN, 1'b1) |-> ##[0:3] underrun_auto_recover)
      else $error("underrun recovery not enabled");
   AST_CAP_MIRROR: assert property (cap_pointer == (config_status_bit20 ? CAP_PTR_PM : 8'h00))
      else $error("cap pointer and mirror bit disagree");
   AST_PM_OFF_LOAD: assert property (ee_load && !ee_data[8] |-> ##[1:3] (cap_pointer == 8'h00 && !config_status_bit20))
      else $error("pm disable not applied");
   AST_FIFO_CODE: assert property (rx_fifo_bytes inside {12'h400, 12'h800})
      else $error("fifo size outside legal set");
   AST_THRESH: assert property (!rx_store_forward |-> rx_threshold_bytes inside {7'h20, 7'h40})
      else $error("threshold outside legal set");
   AST_PERF_RSV: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFF_PERF |-> wb_dat_o[15:8] == 8'h00)
      else $error("counter reserved bits set");
endmodule : cmd_perf_props
bind cmd_perf_regs cmd_perf_props cmd_perf_props_inst (.*);
`default_nettype wire

// ==== tb/host_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
   import cmd_perf_pkg::*;
(
   // clock
   input wire logic clk,
   // wishbone master side
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [7:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat_w,
   input wire logic [31:0] dat_r,
   input wire logic ack
);
   // bus idle at time zero
   initial begin
      {cyc, stb, we, adr, sel, dat_w} = '0;
   end
   // one classic cycle, held until ack is sampled high
   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] s,
         input logic [31:0] d, output logic [31:0] q);
      if (w && a == OFF_COMMAND) d[BIT_LINK_WAKE_SEL] = 1'b0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat_w <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : access
endmodule : host_bus_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cmd_perf_pkg::*;
;
   localparam logic [31:0] BASE = 32'h0040_0004;
   localparam logic [31:0] TV [5] = '{32'h0060_0010, 32'h0040_0014, 32'h0040_0018,
      32'h0040_0000, 32'h0040_0008};
   localparam logic [11:0] FV [5] = '{12'h400, 12'h800, 12'h800, 12'h800, 12'h800};
   localparam logic [6:0] HV [5] = '{7'h20, 7'h40, 7'h00, 7'h40, 7'h40};
   localparam logic SV [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ee_load;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [EE_WIDTH-1:0] ee_data;
   logic pci_reset_pin, power_up, link_change, wake_frame_seen, special_frame_seen;
   logic an_done, an_pause, read_pending, dword_moved, link_up, speed_fast, activity, duplex_col;
   logic wake_out, clkrun_enable, led_speed, led_fast_link, led_slow_link, led_activity;
   logic led_link_act, led_duplex_col, rx_store_forward, pause_enable, underrun_auto_recover;
   logic pattern_pointer_reset, soft_int_status, config_status_bit20;
   logic [11:0] rx_fifo_bytes;
   logic [6:0] rx_threshold_bytes;
   logic [7:0] cap_pointer;
   int mismatches, checks, cycles;
   // ------------------------------------------------------------
   // design and host model
   // ------------------------------------------------------------
   cmd_perf_regs cmd_perf_regs_inst (.*);
   host_bus_model host_bus_model_inst (.clk, .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i),
      .adr(wb_adr_i), .sel(wb_sel_i), .dat_w(wb_dat_i), .dat_r(wb_dat_o), .ack(wb_ack_o));
   // 50 ns clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard, far above the run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check_word
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_bus_model_inst.access(1'b1, a, 4'hF, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host_bus_model_inst.access(1'b0, a, 4'hF, 32'h0, q);
   endtask : rd
   // registered outputs need a few edges
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle
   task automatic pulse_reset_pin();
      @(posedge clk) pci_reset_pin <= 1'b1;
      repeat (4) @(posedge clk);
      pci_reset_pin <= 1'b0;
      settle();
   endtask : pulse_reset_pin
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_reset();
      settle();
      check_word("clkrun", 32'h1, clkrun_enable);
      check_word("fifo", 32'h800, rx_fifo_bytes);
      check_word("thr", 32'h40, rx_threshold_bytes);
      check_word("cap", 32'h40, cap_pointer);
      check_word("underrun", 32'h0, underrun_auto_recover);
      rd(OFF_PERF);
      check_word("perf", 32'h0, q);
      rd(8'hC0);
      check_word("unmapped", 32'h0, q);
   endtask : s_reset
   task automatic s_fifo_drain();
      for (int i = 0; i < 5; i++) begin
         wr(OFF_COMMAND, TV[i]);
         settle();
         check_word("fifo", FV[i], rx_fifo_bytes);
         check_word("saf", SV[i], rx_store_forward);
         if (!SV[i]) check_word("thr", HV[i], rx_threshold_bytes);
         rd(OFF_COMMAND);
         check_word("cmd", TV[i] & 32'h0070_001D, q & 32'h0070_001D);
      end
   endtask : s_fifo_drain
   task automatic s_flags();
      wr(OFF_COMMAND, 32'h0050_00C7);
      settle();
      check_word("clkrun", 32'h0, clkrun_enable);
      check_word("wake", 32'h1, wake_out);
      check_word("ptr", 32'h1, pattern_pointer_reset);
      check_word("softint", 32'h1, soft_int_status);
      check_word("underrun", 32'h1, underrun_auto_recover);
      wr(OFF_COMMAND, BASE);
      settle();
      check_word("wake", 32'h0, wake_out);
      check_word("clkrun", 32'h1, clkrun_enable);
   endtask : s_flags
   task automatic s_pause();
      @(posedge clk) an_done <= 1'b1;
      an_pause <= 1'b1;
      settle();
      check_word("pause", 32'h1, pause_enable);
      wr(OFF_COMMAND, BASE);
      settle();
      check_word("pause", 32'h0, pause_enable);
   endtask : s_pause
   task automatic s_led();
      @(posedge clk) link_up <= 1'b1;
      speed_fast <= 1'b1;
      activity <= 1'b1;
      duplex_col <= 1'b1;
      settle();
      check_word("speed", 32'h1, led_speed);
      check_word("linkact", 32'h1, led_link_act);
      wr(OFF_COMMAND, BASE | 32'h0080_0000);
      settle();
      check_word("fast", 32'h1, led_fast_link);
      check_word("slow", 32'h0, led_slow_link);
      check_word("dupcol", 32'h1, led_duplex_col);
   endtask : s_led
   task automatic s_eeprom();
      @(posedge clk) ee_data <= 9'h01A;
      ee_load <= 1'b1;
      @(posedge clk) ee_load <= 1'b0;
      settle();
      check_word("cap", 32'h0, cap_pointer);
      check_word("bit20", 32'h0, config_status_bit20);
      check_word("fifo", 32'h400, rx_fifo_bytes);
      @(posedge clk) ee_data <= 9'h112;
      ee_load <= 1'b1;
      @(posedge clk) ee_load <= 1'b0;
      settle();
      check_word("cap", 32'h40, cap_pointer);
      check_word("bit20", 32'h1, config_status_bit20);
      rd(OFF_COMMAND);
      check_word("pmbit", 32'h1, q[BIT_PM_EN]);
   endtask : s_eeprom
   task automatic s_power();
      wr(OFF_COMMAND, BASE);
      wr(OFF_PM_STATUS, 32'h3);
      pulse_reset_pin();
      rd(OFF_PM_STATUS);
      check_word("pstate", 32'h3, q[1:0]);
      wr(OFF_COMMAND, BASE | 32'h0200_0000);
      pulse_reset_pin();
      rd(OFF_PM_STATUS);
      check_word("pstate", 32'h0, q[1:0]);
   endtask : s_power
   task automatic s_perf();
      rd(OFF_PERF);
      @(posedge clk) read_pending <= 1'b1;
      dword_moved <= 1'b1;
      repeat (5) @(posedge clk);
      dword_moved <= 1'b0;
      repeat (5) @(posedge clk);
      read_pending <= 1'b0;
      settle();
      rd(OFF_PERF);
      check_word("perf", 32'h000A_0005, q);
      rd(OFF_PERF);
      check_word("perf", 32'h0, q);
      wr(OFF_PERF, 32'hFFFF_FFFF);
      rd(OFF_PERF);
      check_word("perf", 32'h0, q);
   endtask : s_perf
   task automatic report_and_stop();
      if (mismatches == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // main sequence; wake sources stay idle
   initial begin
      {rst, ee_load, pci_reset_pin, power_up, link_change, wake_frame_seen} = 6'h20;
      {special_frame_seen, an_done, an_pause, read_pending, dword_moved} = 5'h00;
      {link_up, speed_fast, activity, duplex_col} = 4'h0;
      ee_data = 9'h000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      s_reset();
      s_fifo_drain();
      s_flags();
      s_pause();
      s_led();
      s_eeprom();
      s_power();
      s_perf();
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
